// File: hdl/async_serial_receiver.v
// asynchronous serial receiver with oversampling recovery, two-word buffer and apb registers
//
// Behaviour
// - input recovered by a sixteen-times oversampling front end before the receive shifter
// - frames accepted only while continuous_rx_enable, status bit 4, is set
// - after the stop bit the word moves from shifter to buffer if room
// - a word moved into the buffer sets rx_full_flag, flag bit 0
// - rx_full_flag raises the interrupt only while rx_irq_enable, bit 0, is set
// - rx_full_flag is read only and clears when the buffer is read empty
// - buffer is a two-entry fifo while a third word shifts in
// - third stop bit with buffer full sets overrun_error, bit 1, and drops word
// - overrun_error stays set until continuous_rx_enable resets the receive logic
// - while overrun_error is set no word enters the buffer
// - framing_error, bit 2, set when the stop bit is not found high
// - framing error and ninth bit travel with their word; read loads next status
// - divisor zero gives the highest rate, 255 the lowest
// - each bit decided by majority of samples seven, eight and nine
`timescale 1ns/1ns
`include "async_rx_regs.vh"
module async_serial_receiver #(
    parameter DIV_WIDTH = 8
) (
    input wire pclk,                // bus and oscillator clock, 10 MHz
    input wire presetn,             // asynchronous reset, active low
    input wire psel,                // apb select
    input wire penable,             // apb access phase
    input wire pwrite,              // apb direction, high for write
    input wire [7:0] paddr,         // apb byte address
    input wire [31:0] pwdata,       // apb write data
    output reg [31:0] prdata,       // apb read data
    output reg pready,              // apb ready
    output reg pslverr,             // apb error for an unmapped address
    input wire serial_rx_pin,       // serial data from the remote transmitter
    output wire irq                 // level interrupt, active high
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg continuous_rx_enable_reg;
reg nine_bit_mode_reg;
reg overrun_error_reg;
reg rx_irq_enable_reg;
reg [2:0] irq_status_reg;
reg [2:0] irq_mask_reg;
reg [DIV_WIDTH-1:0] baud_divisor_reg;

wire access_done;
wire wr_en;
wire rd_en;
wire addr_hit;
wire [9:0] head_data;
wire buf_valid;
wire buf_room;
wire rx_full_flag;
wire buf_pop;
reg [31:0] rdata_next;

// the slave takes one wait state so that read data come from a register
assign access_done = psel && penable && pready;
assign wr_en = access_done && pwrite && addr_hit;
assign rd_en = access_done && !pwrite && addr_hit;
assign addr_hit = (paddr == `RX_STATUS_CONTROL_OFS) || (paddr == `RX_BUFFER_OFS) ||
    (paddr == `PERIPH_IRQ_FLAGS_OFS) || (paddr == `PERIPH_IRQ_ENABLES_OFS) ||
    (paddr == `IRQ_STATUS_OFS) || (paddr == `IRQ_MASK_OFS) ||
    (paddr == `BAUD_DIVISOR_OFS);
assign rx_full_flag = buf_valid;
assign buf_pop = rd_en && (paddr == `RX_BUFFER_OFS);

always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
        `RX_STATUS_CONTROL_OFS: begin
            rdata_next[`NINTH_RX_BIT_POS] = head_data[8];
            rdata_next[`OVERRUN_ERROR_POS] = overrun_error_reg;
            rdata_next[`FRAMING_ERROR_POS] = head_data[9];
            rdata_next[`CONTINUOUS_RX_ENABLE_POS] = continuous_rx_enable_reg;
            rdata_next[`NINE_BIT_MODE_POS] = nine_bit_mode_reg;
        end
        `RX_BUFFER_OFS: rdata_next[7:0] = head_data[7:0];
        `PERIPH_IRQ_FLAGS_OFS: rdata_next[`RX_FULL_FLAG_POS] = rx_full_flag;
        `PERIPH_IRQ_ENABLES_OFS: rdata_next[`RX_IRQ_ENABLE_POS] = rx_irq_enable_reg;
        `IRQ_STATUS_OFS: rdata_next[2:0] = irq_status_reg;
        `IRQ_MASK_OFS: rdata_next[2:0] = irq_mask_reg;
        `BAUD_DIVISOR_OFS: rdata_next[DIV_WIDTH-1:0] = baud_divisor_reg;
        default: rdata_next = 32'h0000_0000;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= psel && penable && !pready;
        pslverr <= psel && penable && !pready && !addr_hit;
        if (psel && penable && !pready && !pwrite)
            prdata <= rdata_next;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        continuous_rx_enable_reg <= 1'b0;
        nine_bit_mode_reg <= 1'b0;
        rx_irq_enable_reg <= 1'b0;
        irq_mask_reg <= 3'h0;
        baud_divisor_reg <= `BAUD_DIVISOR_RESET;
    end else if (wr_en) begin
        case (paddr)
            `RX_STATUS_CONTROL_OFS: begin
                continuous_rx_enable_reg <= pwdata[`CONTINUOUS_RX_ENABLE_POS];
                nine_bit_mode_reg <= pwdata[`NINE_BIT_MODE_POS];
            end
            `PERIPH_IRQ_ENABLES_OFS: rx_irq_enable_reg <= pwdata[`RX_IRQ_ENABLE_POS];
            `IRQ_MASK_OFS: irq_mask_reg <= pwdata[2:0];
            `BAUD_DIVISOR_OFS: baud_divisor_reg <= pwdata[DIV_WIDTH-1:0];
            default: baud_divisor_reg <= baud_divisor_reg;
        endcase
    end
end

// ----------------------------------------------------------------
// pin synchroniser and oversampling clock
// ----------------------------------------------------------------
reg rx_sync1_reg;
reg rx_sync2_reg;
reg rx_sync3_reg;
reg rx_level_reg;
reg [DIV_WIDTH+1:0] prescale_reg;
wire x16_tick;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_sync1_reg <= 1'b1;
        rx_sync2_reg <= 1'b1;
        rx_sync3_reg <= 1'b1;
        rx_level_reg <= 1'b1;
    end else begin
        rx_sync1_reg <= serial_rx_pin;
        rx_sync2_reg <= rx_sync1_reg;
        rx_sync3_reg <= rx_sync2_reg;
        if (rx_sync2_reg == rx_sync3_reg)
            rx_level_reg <= rx_sync3_reg;
    end
end

// one x16 tick every four times (divisor plus one) clocks: rate is pclk / (64 * (d + 1))
assign x16_tick = (prescale_reg == {baud_divisor_reg, 2'b11});

always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        prescale_reg <= {(DIV_WIDTH+2){1'b0}};
    else if (x16_tick || prescale_reg > {baud_divisor_reg, 2'b11})
        prescale_reg <= {(DIV_WIDTH+2){1'b0}};
    else
        prescale_reg <= prescale_reg + 1'b1;
end

// ----------------------------------------------------------------
// receive state machine
// ----------------------------------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_START = 4'b0010;
localparam ST_DATA = 4'b0100;
localparam ST_STOP = 4'b1000;

reg [3:0] state_reg;
reg [3:0] phase_reg;
reg [3:0] bit_cnt_reg;
reg [1:0] samples_reg;
reg [8:0] rx_shift_reg;
wire vote;
wire last_sample;
wire [3:0] last_bit;
wire frame_end;
wire stop_ok;
wire push_valid;
wire push_now;
wire drop_word;

// three samples per bit, the third taken now
assign vote = (samples_reg[0] & samples_reg[1]) | (samples_reg[0] & rx_level_reg) |
    (samples_reg[1] & rx_level_reg);
assign last_sample = x16_tick && (phase_reg == `SAMPLE_C);
assign last_bit = nine_bit_mode_reg ? 4'd8 : 4'd7;
// a frame finishing just as the receiver is disabled is dropped, not stored
assign frame_end = continuous_rx_enable_reg && (state_reg == ST_STOP) && last_sample;
assign stop_ok = vote;
assign push_valid = frame_end && !overrun_error_reg;
assign push_now = push_valid && buf_room;
assign drop_word = push_valid && !buf_room;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= ST_IDLE;
        phase_reg <= 4'h0;
        bit_cnt_reg <= 4'h0;
        samples_reg <= 2'b00;
        rx_shift_reg <= 9'h000;
    end else if (!continuous_rx_enable_reg) begin
        state_reg <= ST_IDLE;
        phase_reg <= 4'h0;
        bit_cnt_reg <= 4'h0;
    end else begin
        if (x16_tick) begin
            phase_reg <= phase_reg + 4'h1;
            if (phase_reg == `SAMPLE_A)
                samples_reg[0] <= rx_level_reg;
            if (phase_reg == `SAMPLE_B)
                samples_reg[1] <= rx_level_reg;
        end
        case (state_reg)
            ST_IDLE: begin
                // the falling edge of the start bit realigns the x16 phase
                if (!rx_level_reg) begin
                    state_reg <= ST_START;
                    phase_reg <= 4'h0;
                end
            end
            ST_START: begin
                if (last_sample) begin
                    // a start bit that votes high was a glitch
                    if (vote)
                        state_reg <= ST_IDLE;
                    else
                        state_reg <= ST_DATA;
                    bit_cnt_reg <= 4'h0;
                end
            end
            ST_DATA: begin
                if (last_sample) begin
                    rx_shift_reg[bit_cnt_reg] <= vote;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == last_bit)
                        state_reg <= ST_STOP;
                end
            end
            ST_STOP: begin
                // back to idle at once so a low line is taken as the next start bit
                if (last_sample)
                    state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

// overrun holds until the receiver is disabled; both cannot happen together
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        overrun_error_reg <= 1'b0;
    else if (!continuous_rx_enable_reg)
        overrun_error_reg <= 1'b0;
    else if (drop_word)
        overrun_error_reg <= 1'b1;
end

// ----------------------------------------------------------------
// receive buffer
// ----------------------------------------------------------------
rx_word_fifo #(
    .WIDTH(10)
) u_rx_buffer (
    .clk(pclk),
    .rst_n(presetn),
    .push_valid(push_valid),
    .push_ready(buf_room),
    .push_data({!stop_ok, nine_bit_mode_reg & rx_shift_reg[8], rx_shift_reg[7:0]}),
    .pop_valid(buf_valid),
    .pop_ready(buf_pop),
    .head_data(head_data)
);

// ----------------------------------------------------------------
// interrupts
// ----------------------------------------------------------------
wire [2:0] events;

assign events = {frame_end && !stop_ok, drop_word, push_now};

// a read clears the sticky bits, but an event in the same cycle survives it
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        irq_status_reg <= 3'h0;
    else if (rd_en && paddr == `IRQ_STATUS_OFS)
        irq_status_reg <= events;
    else
        irq_status_reg <= irq_status_reg | events;
end

assign irq = (rx_full_flag && rx_irq_enable_reg) || (|(irq_status_reg & irq_mask_reg));

endmodule // async_serial_receiver

// File: hdl/async_rx_regs.vh
// register offsets, field positions and reset values of the asynchronous serial receiver
`ifndef ASYNC_RX_REGS_VH
`define ASYNC_RX_REGS_VH

`define RX_STATUS_CONTROL_OFS 8'h00
`define RX_BUFFER_OFS 8'h04
`define PERIPH_IRQ_FLAGS_OFS 8'h08
`define PERIPH_IRQ_ENABLES_OFS 8'h0c
`define IRQ_STATUS_OFS 8'h10
`define IRQ_MASK_OFS 8'h14
`define BAUD_DIVISOR_OFS 8'h18

`define NINTH_RX_BIT_POS 0
`define OVERRUN_ERROR_POS 1
`define FRAMING_ERROR_POS 2
`define CONTINUOUS_RX_ENABLE_POS 4
`define NINE_BIT_MODE_POS 6
`define RX_FULL_FLAG_POS 0
`define RX_IRQ_ENABLE_POS 0

`define EV_WORD_POS 0
`define EV_OVERRUN_POS 1
`define EV_FRAMING_POS 2

`define BAUD_DIVISOR_RESET 8'h00
`define OVERSAMPLE 16
`define PCLK_PER_X16_UNIT 4
`define SAMPLE_A 4'h6
`define SAMPLE_B 4'h7
`define SAMPLE_C 4'h8

`endif

// File: hdl/rx_word_fifo.v
// two-entry word buffer holding each received word with its status bits
`timescale 1ns/1ns
module rx_word_fifo #(
    parameter WIDTH = 10
) (
    input wire clk,                 // clock
    input wire rst_n,               // asynchronous reset, active low
    input wire push_valid,          // word offered by the receiver
    output wire push_ready,         // buffer has room
    input wire [WIDTH-1:0] push_data, // word with status bits
    output wire pop_valid,          // buffer holds a word
    input wire pop_ready,           // consumer takes the head word
    output wire [WIDTH-1:0] head_data // head word, straight from a register
);

reg [WIDTH-1:0] entry0_reg;
reg [WIDTH-1:0] entry1_reg;
reg [1:0] count_reg;
wire do_push;
wire do_pop;

assign push_ready = (count_reg != 2'd2);
assign pop_valid = (count_reg != 2'd0);
assign do_push = push_valid && push_ready;
assign do_pop = pop_ready && pop_valid;
assign head_data = entry0_reg;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        entry0_reg <= {WIDTH{1'b0}};
        entry1_reg <= {WIDTH{1'b0}};
        count_reg <= 2'd0;
    end else begin
        // popping moves the second word to the head, so its status appears at once
        if (do_pop) begin
            if (do_push && count_reg == 2'd1)
                entry0_reg <= push_data;
            else
                entry0_reg <= entry1_reg;
            if (do_push && count_reg == 2'd2)
                entry1_reg <= push_data;
        end else if (do_push) begin
            if (count_reg == 2'd0)
                entry0_reg <= push_data;
            else
                entry1_reg <= push_data;
        end
        if (do_push && !do_pop)
            count_reg <= count_reg + 2'd1;
        else if (do_pop && !do_push)
            count_reg <= count_reg - 2'd1;
    end
end

endmodule // rx_word_fifo

// File: verification/async_rx_asserts.sv
// port checks for the asynchronous serial receiver
`timescale 1ns/1ns
`include "async_rx_regs.vh"
module async_rx_asserts (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // apb select
    input wire penable, // apb access
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb address
    input wire [31:0] pwdata, // apb write data
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire serial_rx_pin, // serial line
    input wire irq // interrupt
);
    // ------------------------------------------------------------
    // shadow of software settings, updated at the write effect edge
    // ------------------------------------------------------------
    reg en_reg;
    reg ie_reg;
    reg [2:0] mask_reg;
    wire done = psel && penable && pready;
    wire rd_status = done && !pwrite && paddr == `RX_STATUS_CONTROL_OFS;
    wire mapped = paddr[1:0] == 2'b00 && paddr <= `BAUD_DIVISOR_OFS;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
            ie_reg <= 1'b0;
            mask_reg <= 3'h0;
        end else if (done && pwrite) begin
            if (paddr == `RX_STATUS_CONTROL_OFS)
                en_reg <= pwdata[`CONTINUOUS_RX_ENABLE_POS];
            if (paddr == `PERIPH_IRQ_ENABLES_OFS)
                ie_reg <= pwdata[`RX_IRQ_ENABLE_POS];
            if (paddr == `IRQ_MASK_OFS)
                mask_reg <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_in_access: assert property ($rose(pready) |-> psel && penable && $past(penable))
        else $error("pready outside access");
    a_err_map: assert property (done |-> pslverr == !mapped) else $error("pslverr wrong");
    a_err_read_zero: assert property (done && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_irq_gated: assert property (!ie_reg && mask_reg == 3'h0 |-> !irq)
        else $error("irq while disabled");
    a_enable_echo: assert property (rd_status |-> prdata[4] == en_reg)
        else $error("enable bit not held");
    a_overrun_clear: assert property (rd_status && !en_reg |-> !prdata[1])
        else $error("overrun kept while disabled");
    cover property (done && pslverr);
    cover property ($rose(irq));
    cover property (rd_status && prdata[1]);
endmodule // async_rx_asserts

bind async_serial_receiver async_rx_asserts chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(serial_rx_pin), .irq(irq));

// File: verification/serial_tx_model.sv
// remote asynchronous transmitter driving the receive pin
`timescale 1ns/1ns
module serial_tx_model #(
    parameter BIT_CLKS = 64
) (
    input wire pclk, // clock
    output reg line // serial line, idle high
);
    integer bit_clks; // bit length in clocks, may be changed between frames
    initial begin
        line = 1'b1;
        bit_clks = BIT_CLKS;
    end
    // a bad stop is held low only 3/4 bit so no false start is voted in
    task frame(input [8:0] data, input integer nbits, input stop);
        integer i;
        begin
            line <= 1'b0;
            repeat (bit_clks) @(posedge pclk);
            for (i = 0; i < nbits; i = i + 1) begin
                line <= data[i];
                repeat (bit_clks) @(posedge pclk);
            end
            line <= stop;
            repeat (bit_clks * 3 / 4) @(posedge pclk);
            line <= 1'b1;
            repeat (bit_clks + 16) @(posedge pclk);
        end
    endtask
    task send(input [7:0] data, input stop);
        begin
            frame({1'b0, data}, 8, stop);
        end
    endtask
    task send9(input [8:0] data, input stop);
        begin
            frame(data, 9, stop);
        end
    endtask
endmodule // serial_tx_model

// File: verification/tb_async_serial_receiver.sv
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ns
`include "async_rx_regs.vh"
module tb_async_serial_receiver;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire irq;
    wire rx_line;
    integer bad_count = 0;
    integer tests_run = 0;
    always #50 pclk = ~pclk;
    async_serial_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_rx_pin(rx_line), .irq(irq));
    serial_tx_model remote (.pclk(pclk), .line(rx_line));
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task apb(input wr, input [7:0] addr, input [31:0] data);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= data;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task check(input [31:0] exp, input [31:0] got, input [8*8:1] name);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task rd_chk(input [7:0] addr, input [31:0] exp);
        begin
            apb(1'b0, addr, 32'h0);
            check(exp, rd, "register");
        end
    endtask
    task close_out;
        begin
            if (bad_count == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h0);
        rd_chk(`BAUD_DIVISOR_OFS, {24'h0, `BAUD_DIVISOR_RESET});
        apb(1'b1, 8'h40, 32'h1);
        check(32'h1, {31'h0, err}, "pslverr");
        rd_chk(8'h40, 32'h0);
        apb(1'b1, `PERIPH_IRQ_ENABLES_OFS, 32'h1);
        apb(1'b1, `IRQ_MASK_OFS, 32'h7);
        remote.send(8'h3c, 1'b1);
        rd_chk(`PERIPH_IRQ_FLAGS_OFS, 32'h0);
        apb(1'b1, `RX_STATUS_CONTROL_OFS, 32'h10);
        remote.send(8'ha5, 1'b1);
        rd_chk(`PERIPH_IRQ_FLAGS_OFS, 32'h1);
        check(32'h1, {31'h0, irq}, "irq");
        apb(1'b1, `PERIPH_IRQ_ENABLES_OFS, 32'h0);
        rd_chk(`IRQ_STATUS_OFS, 32'h1);
        check(32'h0, {31'h0, irq}, "irq");
        rd_chk(`IRQ_STATUS_OFS, 32'h0);
        apb(1'b1, `PERIPH_IRQ_FLAGS_OFS, 32'h0);
        rd_chk(`PERIPH_IRQ_FLAGS_OFS, 32'h1);
        rd_chk(`RX_BUFFER_OFS, 32'ha5);
        rd_chk(`PERIPH_IRQ_FLAGS_OFS, 32'h0);
        remote.send(8'h5a, 1'b0);
        remote.send(8'hc3, 1'b1);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h14);
        rd_chk(`RX_BUFFER_OFS, 32'h5a);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h10);
        remote.send(8'h77, 1'b1);
        remote.send(8'h11, 1'b1);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h12);
        rd_chk(`RX_BUFFER_OFS, 32'hc3);
        remote.send(8'h22, 1'b1);
        rd_chk(`RX_BUFFER_OFS, 32'h77);
        rd_chk(`PERIPH_IRQ_FLAGS_OFS, 32'h0);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h12);
        apb(1'b1, `RX_STATUS_CONTROL_OFS, 32'h0);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h0);
        apb(1'b1, `RX_STATUS_CONTROL_OFS, 32'h10);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h10);
        remote.send(8'h99, 1'b1);
        rd_chk(`RX_BUFFER_OFS, 32'h99);
        apb(1'b1, `RX_STATUS_CONTROL_OFS, 32'h50);
        remote.send9(9'h1c6, 1'b1);
        rd_chk(`RX_STATUS_CONTROL_OFS, 32'h51);
        rd_chk(`RX_BUFFER_OFS, 32'hc6);
        apb(1'b1, `RX_STATUS_CONTROL_OFS, 32'h10);
        apb(1'b1, `BAUD_DIVISOR_OFS, 32'h1);
        rd_chk(`BAUD_DIVISOR_OFS, 32'h1);
        remote.bit_clks = 128;
        remote.send(8'h4b, 1'b1);
        rd_chk(`RX_BUFFER_OFS, 32'h4b);
        close_out;
    end
endmodule // tb_async_serial_receiver
